// *** design/sepa_pkg.sv ***
`default_nettype none
package sepa_pkg;

  // array geometry: 2048-byte array, 32-byte pages, 16 address clocks
  localparam int addr_w     = 11;
  localparam int mem_bytes  = 2048;
  localparam int page_w     = 5;
  localparam int page_bytes = 32;

  // instruction codes
  localparam logic [7:0] set_write_latch_cmd   = 8'h06;
  localparam logic [7:0] clear_write_latch_cmd = 8'h04;
  localparam logic [7:0] status_read_cmd       = 8'h05;
  localparam logic [7:0] status_write_cmd      = 8'h01;
  localparam logic [7:0] array_read_cmd        = 8'h03;
  localparam logic [7:0] array_write_cmd       = 8'h02;
  // what a status read shifts out while programming runs
  localparam logic [7:0] busy_readout          = 8'hFF;

  // status word field positions
  localparam int         st_protect  = 7;
  localparam int         st_guard_hi = 4;
  localparam int         st_guard_lo = 2;
  localparam int         st_latch    = 1;
  localparam int         st_busy     = 0;
  localparam logic [1:0] st_ones     = 2'h3;

  // internal write cycle time
  localparam int clk_period_ns = 10;
  localparam int write_time_ns = 5000000;
  localparam int write_cycles  = write_time_ns / clk_period_ns;
  localparam int tmr_w         = 20;

  // link sequencer states
  typedef enum logic [2:0] {
    l_cmd    = 3'h0,
    l_addr   = 3'h1,
    l_rdata  = 3'h2,
    l_wdata  = 3'h3,
    l_stat   = 3'h4,
    l_swdata = 3'h5,
    l_done   = 3'h6,
    l_dead   = 3'h7
  } sepa_lstate_t;

  // what a frame asked for, handed to the system side at the frame end
  typedef enum logic [2:0] {
    k_none = 3'h0,
    k_set  = 3'h1,
    k_clr  = 3'h2,
    k_swr  = 3'h3,
    k_wr   = 3'h4,
    k_rd   = 3'h5,
    k_stat = 3'h6
  } sepa_kind_t;

  // guarded range for each block-guard code
  function automatic logic sepa_in_guard(input logic [2:0] guard, input logic [addr_w-1:0] a);
    logic hit;
    hit = 1'b0;
    unique case (guard)
      3'h0: hit = 1'b0;
      3'h1: hit = (a[10:9] == 2'h0);
      3'h2: hit = (a[10:9] == 2'h1);
      3'h3: hit = (a[10:9] == 2'h2);
      3'h4: hit = (a[10:9] == 2'h3);
      3'h5: hit = ~a[10];
      3'h6: hit = (a[10:5] == 6'h00);
      3'h7: hit = (a[10:5] == 6'h3F);
    endcase
    return hit;
  endfunction

endpackage
`default_nettype wire

// *** design/sepa_core.sv ***
// Contract
// - hardware lock refuses status writes, array still writable
// - guarded array range is never programmed
// - protect pin ignored when protect enable clear
// - pause freezes sequence, output released
// - busy flag reads one while programming
// - latch set only by its command, cleared by its command or write end
// - guard bits change only via status write
// - latch starts cleared after reset
// - read: opcode then sixteen address bits
// - sequential read increments, wraps to zero
// - select high ends read, releases output
// - status read gives ones while busy
// - programming starts at select rising edge
// - write in latch-setting frame is ignored
// - every target must be outside guard
// - page write wraps within 32-byte page
// - write completion clears the latch
// - status write changes bits 7,4,3,2
// - exact clock count; ignore access while busy
// - unknown opcode: deaf and quiet till reselect
// - output released until read drives it
// - latch and status read opcodes
// - status write, read, write opcodes
// - status word field layout
// - sample on rising, shift on falling
`timescale 1ns/100ps
`default_nettype none
module sepa_core #(
  parameter int unsigned write_cycles_p = sepa_pkg::write_cycles
) (
  // system clock and reset
  input  wire logic clock,
  input  wire logic nrst,
  // serial link from the host
  input  wire logic spi_clk,
  input  wire logic spi_sel_n,
  input  wire logic spi_din,
  input  wire logic pause_n,
  input  wire logic protect_n,
  // serial output, three-state
  output var  logic spi_dout,
  output var  logic spi_dout_oe
);
  import sepa_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state types

  // link-side state, clocked by the serial clock
  typedef struct packed {
    sepa_lstate_t           lstate;       // sequencer position
    logic [2:0]             bitcnt;       // bit within current byte
    logic [7:0]             shin;         // incoming shift register
    logic                   addr_hi_done; // first address byte taken
    logic [addr_w-1:0]      addr;         // array pointer
    sepa_kind_t             kind;         // frame request
    logic [5:0]             nbytes;       // data bytes taken, saturating
    logic [page_bytes-1:0]  pmask;        // page offsets loaded
    logic [7:0]             shout;        // outgoing shift register
    logic                   drive;        // output should be driven
    logic [7:0]             swr_data;     // status write byte
    logic [7:0]             stat_s1;      // status sync, first stage
    logic [7:0]             stat_s2;      // status sync, second stage
  } sepa_link_t;

  // system-side state
  typedef struct packed {
    logic                    sel_s1;             // select sync
    logic                    sel_s2;
    logic                    sel_s3;             // edge history
    logic                    prot_s1;            // protect pin sync
    logic                    prot_s2;
    logic                    pin_protect_enable; // status bit 7
    logic [2:0]              block_guard;        // status bits 4..2
    logic                    write_latch_flag;   // status bit 1
    logic                    busy;               // status bit 0
    logic [tmr_w-1:0]        tmr;                // write cycle countdown
    logic                    prog;               // page copy running
    logic [page_w-1:0]       pidx;               // page copy index
    logic [addr_w-1:page_w]  base;               // page being programmed
    logic [page_bytes-1:0]   pmask;              // offsets to program
  } sepa_sys_t;

  // reset image; guard bits model a blank part at first power-up
  localparam sepa_sys_t sys_rst = '{
    sel_s1: 1'b1, sel_s2: 1'b1, sel_s3: 1'b1, prot_s1: 1'b1, prot_s2: 1'b1,
    pin_protect_enable: 1'b0, block_guard: 3'h0, write_latch_flag: 1'b0,
    busy: 1'b0, tmr: '0, prog: 1'b0, pidx: '0, base: '0, pmask: '0};

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  sepa_link_t              l;              // link state
  sepa_link_t              cur;            // link state after frame restart
  sepa_link_t              next_l;         // next link state
  sepa_sys_t               s;              // system state
  sepa_sys_t               next_s;         // next system state
  logic                    fresh;          // first edge of a frame pending
  logic [7:0]              byte_in;        // byte completed by this edge
  logic                    link_busy;      // busy as seen by the link
  logic                    pb_we;          // page buffer write strobe
  logic [page_w-1:0]       pb_idx;         // page buffer write index
  logic [7:0]              pbuf [page_bytes]; // page buffer
  logic [7:0]              mem [mem_bytes];   // the array
  logic [7:0]              status_word;    // device_status_word
  logic                    sel_rise;       // frame end, system side
  logic                    frame_ok;       // frame ended on byte boundary
  logic                    hw_lock;        // hardware protection active
  logic [page_bytes-1:0]   hit;            // loaded offset inside guard
  logic                    mem_we;         // array write strobe
  logic [addr_w-1:0]       mem_wa;         // array write address

  ////////////////////////////////////////////////////////////////////////////
  // link side: frame restart marker

  // set while select is high; the first sampling edge clears it.
  // the host keeps the clock still between frames, so nothing is lost
  always_ff @(posedge spi_clk or posedge spi_sel_n)
  begin
    if (spi_sel_n)
      fresh <= 1'b1;
    else if (pause_n)
      fresh <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // link side: sequencer, sampling on the rising serial clock

  always_comb
  begin
    cur = l;
    // a new frame starts from the instruction byte
    if (fresh)
    begin
      cur.lstate       = l_cmd;
      cur.bitcnt       = 3'h0;
      cur.addr_hi_done = 1'b0;
      cur.kind         = k_none;
      cur.nbytes       = 6'h00;
      cur.pmask        = '0;
      cur.drive        = 1'b0;
    end
    next_l         = cur;
    byte_in        = {cur.shin[6:0], spi_din};
    link_busy      = l.stat_s2[st_busy];
    pb_we          = 1'b0;
    pb_idx         = cur.addr[page_w-1:0];
    // status word crosses as a slow level through two stages
    next_l.stat_s1 = status_word;
    next_l.stat_s2 = l.stat_s1;
    // a paused link ignores the data line and keeps its place
    if (pause_n)
    begin
      next_l.shin   = byte_in;
      next_l.bitcnt = cur.bitcnt + 3'h1;
      unique case (cur.lstate)
        // instruction byte
        l_cmd:
          if (cur.bitcnt == 3'h7)
          begin
            if (byte_in == status_read_cmd)
            begin
              next_l.kind   = k_stat;
              next_l.lstate = l_stat;
              next_l.shout  = link_busy ? busy_readout : l.stat_s2;
              next_l.drive  = 1'b1;
            end
            else if (byte_in == set_write_latch_cmd || byte_in == clear_write_latch_cmd)
            begin
              // latch commands while busy are dropped
              next_l.kind   = link_busy ? k_none :
                              (byte_in == set_write_latch_cmd ? k_set : k_clr);
              next_l.lstate = l_done;
            end
            else if (byte_in == status_write_cmd)
            begin
              next_l.kind   = link_busy ? k_none : k_swr;
              next_l.lstate = link_busy ? l_done : l_swdata;
            end
            else if (byte_in == array_read_cmd || byte_in == array_write_cmd)
            begin
              // array access during programming is ignored
              next_l.kind   = link_busy ? k_none :
                              (byte_in == array_read_cmd ? k_rd : k_wr);
              next_l.lstate = link_busy ? l_done : l_addr;
            end
            else
              next_l.lstate = l_dead;
          end
        // two address bytes, upper bits beyond the array ignored
        l_addr:
          if (cur.bitcnt == 3'h7)
          begin
            if (!cur.addr_hi_done)
            begin
              next_l.addr[addr_w-1:8] = byte_in[addr_w-9:0];
              next_l.addr_hi_done     = 1'b1;
            end
            else if (cur.kind == k_rd)
            begin
              next_l.shout  = mem[{cur.addr[addr_w-1:8], byte_in}];
              next_l.addr   = {cur.addr[addr_w-1:8], byte_in} + 11'h001;
              next_l.drive  = 1'b1;
              next_l.lstate = l_rdata;
            end
            else
            begin
              next_l.addr   = {cur.addr[addr_w-1:8], byte_in};
              next_l.lstate = l_wdata;
            end
          end
        // sequential read, pointer wraps past the top
        l_rdata:
          if (cur.bitcnt == 3'h7)
          begin
            next_l.shout = mem[cur.addr];
            next_l.addr  = cur.addr + 11'h001;
          end
          else
            next_l.shout = {cur.shout[6:0], 1'b0};
        // status read repeats the live status each byte
        l_stat:
          if (cur.bitcnt == 3'h7)
            next_l.shout = link_busy ? busy_readout : l.stat_s2;
          else
            next_l.shout = {cur.shout[6:0], 1'b0};
        // page data, only the in-page bits advance
        l_wdata:
          if (cur.bitcnt == 3'h7)
          begin
            pb_we                       = 1'b1;
            next_l.pmask[pb_idx]        = 1'b1;
            next_l.addr[page_w-1:0]     = cur.addr[page_w-1:0] + 5'h01;
            next_l.nbytes               = (cur.nbytes == 6'h20) ? cur.nbytes : cur.nbytes + 6'h01;
          end
        // one status byte, later bits only count clocks
        l_swdata:
          if (cur.bitcnt == 3'h7)
          begin
            next_l.swr_data = byte_in;
            next_l.nbytes   = 6'h01;
            next_l.lstate   = l_done;
          end
        // finished or dead: count clocks, drive nothing
        l_done,
        l_dead:
          next_l.drive = 1'b0;
      endcase
    end
  end

  // link state register
  always_ff @(posedge spi_clk)
  begin
    l <= next_l;
  end

  // page buffer; later bytes to the same offset overwrite
  always_ff @(posedge spi_clk)
  begin
    if (pb_we)
      pbuf[pb_idx] <= byte_in;
  end

  ////////////////////////////////////////////////////////////////////////////
  // link side: output on the falling serial clock

  // select high releases the line at once
  // limitation: pause is seen at the next falling edge, not instantly
  always_ff @(negedge spi_clk or posedge spi_sel_n)
  begin
    if (spi_sel_n)
    begin
      spi_dout    <= 1'b0;
      spi_dout_oe <= 1'b0;
    end
    else
    begin
      spi_dout    <= l.shout[7];
      spi_dout_oe <= l.drive & pause_n & ~fresh;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // system side: commit at frame end, write cycle timing

  // guard check over every loaded page offset
  for (genvar g = 0; g < page_bytes; g++)
  begin : g_guard
    assign hit[g] = l.pmask[g] & sepa_in_guard(s.block_guard, {l.addr[addr_w-1:page_w], page_w'(g)});
  end

  // status word image
  assign status_word = {s.pin_protect_enable, st_ones, s.block_guard, s.write_latch_flag, s.busy};

  // array write port fed by the page copy
  assign mem_we = s.prog & s.pmask[s.pidx];
  assign mem_wa = {s.base, s.pidx};

  always_comb
  begin
    next_s         = s;
    next_s.sel_s1  = spi_sel_n;
    next_s.sel_s2  = s.sel_s1;
    next_s.sel_s3  = s.sel_s2;
    next_s.prot_s1 = protect_n;
    next_s.prot_s2 = s.prot_s1;
    // link fields are still because the host clock is idle now
    sel_rise = s.sel_s2 & ~s.sel_s3;
    frame_ok = (l.bitcnt == 3'h0) && (l.nbytes != 6'h00);
    // pin counts only with enable set; pin high means unlocked
    hw_lock  = s.pin_protect_enable & ~s.prot_s2;
    // write cycle countdown, latch cleared when it ends
    if (s.busy)
    begin
      if (s.tmr == '0)
      begin
        next_s.busy             = 1'b0;
        next_s.write_latch_flag = 1'b0;
      end
      else
        next_s.tmr = s.tmr - 20'h00001;
    end
    // page copy, one byte per clock, well inside the cycle time
    if (s.prog)
    begin
      next_s.pidx = s.pidx + 5'h01;
      if (s.pidx == 5'h1F)
        next_s.prog = 1'b0;
    end
    // frame end starts the work, never an earlier edge
    if (sel_rise && !s.busy)
    begin
      unique case (l.kind)
        // latch takes effect only after select rises
        k_set:
          if (l.bitcnt == 3'h0)
            next_s.write_latch_flag = 1'b1;
        k_clr:
          if (l.bitcnt == 3'h0)
            next_s.write_latch_flag = 1'b0;
        // status write: locked by pin and enable
        k_swr:
          if (frame_ok && s.write_latch_flag && !hw_lock)
          begin
            next_s.pin_protect_enable = l.swr_data[st_protect];
            next_s.block_guard        = l.swr_data[st_guard_hi:st_guard_lo];
            next_s.busy               = 1'b1;
            next_s.tmr                = tmr_w'(write_cycles_p - 1);
          end
        // array write: unguarded sections only, pin irrelevant
        k_wr:
          if (frame_ok && s.write_latch_flag && (hit == '0))
          begin
            next_s.busy  = 1'b1;
            next_s.tmr   = tmr_w'(write_cycles_p - 1);
            next_s.prog  = 1'b1;
            next_s.pidx  = 5'h00;
            next_s.base  = l.addr[addr_w-1:page_w];
            next_s.pmask = l.pmask;
          end
        // reads, status reads and empty frames leave nothing to do
        default:
          next_s.prog = s.prog;
      endcase
    end
  end

  // system state register; reset clears the latch
  always_ff @(posedge clock)
  begin
    if (!nrst)
      s <= sys_rst;
    else
      s <= next_s;
  end

  // array storage, no reset: contents survive
  always_ff @(posedge clock)
  begin
    if (mem_we)
      mem[mem_wa] <= pbuf[s.pidx];
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  // busy starts with the full count
  busy_count_a: assert property (@(posedge clock) disable iff (!nrst)
    $rose(s.busy) |-> s.tmr == tmr_w'(write_cycles_p - 1))
    else $error("write timer not loaded on busy start");

  // latch falls with busy
  latch_clear_a: assert property (@(posedge clock) disable iff (!nrst)
    $fell(s.busy) |-> !s.write_latch_flag)
    else $error("latch still set after write cycle");

  // locked status write has no effect
  lock_refuse_a: assert property (@(posedge clock) disable iff (!nrst)
    (sel_rise && l.kind == k_swr && hw_lock) |=> ($stable(s.block_guard) && !$rose(s.busy)))
    else $error("status write taken under hardware lock");

  // no array write inside the guard
  guard_write_a: assert property (@(posedge clock) disable iff (!nrst)
    mem_we |-> !sepa_in_guard(s.block_guard, mem_wa))
    else $error("guarded location programmed");

  // status write copies only the writable bits
  status_bits_a: assert property (@(posedge clock) disable iff (!nrst)
    (sel_rise && !s.busy && l.kind == k_swr && frame_ok && s.write_latch_flag && !hw_lock)
    |=> (s.block_guard == l.swr_data[4:2]) && (s.pin_protect_enable == l.swr_data[7]))
    else $error("status write fields wrong");

  // programming starts only at a frame end
  start_edge_a: assert property (@(posedge clock) disable iff (!nrst)
    $rose(s.busy) |-> $past(sel_rise))
    else $error("write cycle began without select rising");

  // latch rises only from its command
  latch_set_a: assert property (@(posedge clock) disable iff (!nrst)
    $rose(s.write_latch_flag) |-> $past(sel_rise && l.kind == k_set))
    else $error("latch set without its command");

  // page copy stays inside the write cycle
  copy_busy_a: assert property (@(posedge clock) disable iff (!nrst)
    s.prog |-> s.busy ##1 s.busy)
    else $error("page copy outside busy");

  // a dead frame never drives the output
  dead_quiet_a: assert property (@(posedge spi_clk) disable iff (spi_sel_n)
    (l.lstate == l_dead && !fresh) |-> !l.drive)
    else $error("output driven after unknown opcode");

  // main scenarios
  byte_write_c: cover property (@(posedge clock) disable iff (!nrst)
    $rose(s.prog));
  status_read_c: cover property (@(posedge spi_clk) disable iff (spi_sel_n)
    l.lstate == l_stat);
  refused_c: cover property (@(posedge clock) disable iff (!nrst)
    sel_rise && l.kind == k_wr && hit != '0);
  read_wrap_c: cover property (@(posedge spi_clk) disable iff (spi_sel_n)
    l.lstate == l_rdata && l.addr == 11'h000);

endmodule
`default_nettype wire

// *** verification/sepa_host.sv ***
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////
// host model: link clock runs only inside frames, 48 ns period
module sepa_host (
  // link to device
  output var  logic spi_clk,
  output var  logic spi_sel_n,
  output var  logic spi_din,
  output var  logic pause_n,
  // device answer
  input  wire logic spi_dout,
  input  wire logic spi_dout_oe
);
  logic last;  // last level seen on data out
  logic mode3; // clock idles high between frames
  logic lvl;   // released line shows inverse level
  assign lvl = spi_dout_oe ? spi_dout : ~last;
  initial
  begin
    spi_clk   = 1'b0;  // mode 0 idle low
    spi_sel_n = 1'b0;  // pulsed high so the frame marker starts known
    spi_din   = 1'b0;
    pause_n   = 1'b1;  // high unless a hold runs
    last      = 1'b0;
    mode3     = 1'b0;
    #1 spi_sel_n = 1'b1;
  end
  // select falls with clock at its idle level, low in mode 0, high in mode 3
  task automatic sel_on();
    spi_clk = mode3;
    #13 spi_sel_n = 1'b0;
    #24;
  endtask
  // select rises on a byte boundary, then stays high
  task automatic sel_off();
    spi_clk = mode3;
    #24 spi_sel_n = 1'b1;
    #60;
  endtask
  // byte msb first, fall shifts, rise samples
  task automatic xfer(input logic [7:0] b, output logic [7:0] r);
    for (int i = 7; i >= 0; i--)
    begin
      spi_clk = 1'b0;
      spi_din = b[i];
      #24 spi_clk = 1'b1;
      r[i] = lvl;
      last = lvl;
      #24;
    end
  endtask
  // pause with clock low, clocks and data toggle meanwhile
  task automatic hold(input int n, output logic q);
    spi_clk = 1'b0;
    #12 pause_n = 1'b0;
    repeat (n)
    begin
      spi_din = ~spi_din;
      #24 spi_clk = 1'b1;
      #24 spi_clk = 1'b0;
    end
    #12 q = spi_dout_oe;
    pause_n = 1'b1;
    #12;
  endtask
endmodule
`default_nettype wire

// *** verification/spi_eeprom_protect_access_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module spi_eeprom_protect_access_tb;
  import sepa_pkg::*;
  localparam int wc = 300;  // short, yet spans a read frame after a write
  logic clock, nrst, protect_n, seen_oe, q;
  logic spi_clk, spi_sel_n, spi_din, pause_n, spi_dout, spi_dout_oe;
  int errors, compares;
  logic [7:0] mem [mem_bytes];  // expected array
  logic [7:0] r, st;
  sepa_core #(.write_cycles_p(wc)) dut_u (
    .clock(clock), .nrst(nrst), .spi_clk(spi_clk), .spi_sel_n(spi_sel_n),
    .spi_din(spi_din), .pause_n(pause_n), .protect_n(protect_n),
    .spi_dout(spi_dout), .spi_dout_oe(spi_dout_oe));
  sepa_host host_u (
    .spi_clk(spi_clk), .spi_sel_n(spi_sel_n), .spi_din(spi_din),
    .pause_n(pause_n), .spi_dout(spi_dout), .spi_dout_oe(spi_dout_oe));
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // any drive of the output since last cleared
  always @(posedge spi_dout_oe)
    seen_oe = 1'b1;
  ////////////////////////////////////////
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e)
    begin
      errors++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic complete_run();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  function automatic logic [7:0] stat(input logic pe, input logic [2:0] g, input logic l);
    return {pe, st_ones, g, l, 1'b0};
  endfunction
  // opcode then n copies of v
  task automatic frm(input logic [7:0] op, input logic [7:0] v, input int n, output logic [7:0] s);
    host_u.sel_on();
    host_u.xfer(op, s);
    repeat (n)
      host_u.xfer(v, s);
    host_u.sel_off();
  endtask
  // opcode and address, unused high bits random
  task automatic hdr(input logic [7:0] op, input logic [10:0] a);
    host_u.xfer(op, r);
    host_u.xfer({5'($urandom), a[10:8]}, r);
    host_u.xfer(a[7:0], r);
  endtask
  task automatic wr(input logic [10:0] a, input int n, input bit ok, input bit pre, input bit hp);
    logic [7:0] d;
    logic [10:0] p;
    p = a;
    host_u.sel_on();
    if (pre)
      host_u.xfer(set_write_latch_cmd, r);
    hdr(array_write_cmd, a);
    if (hp)
      host_u.hold(3, q);
    repeat (n)
    begin
      d = 8'($urandom);
      host_u.xfer(d, r);
      if (ok)
        mem[p] = d;
      p[4:0] = p[4:0] + 5'h01;  // in-page wrap
    end
    host_u.sel_off();
  endtask
  task automatic rd(input logic [10:0] a, input int n);
    logic [10:0] p;
    p = a;
    host_u.sel_on();
    hdr(array_read_cmd, a);
    repeat (n)
    begin
      host_u.xfer(8'h00, r);
      chk("read", mem[p], r);
      p = p + 11'h001;
    end
    host_u.sel_off();
    chk("oe", 8'h00, {7'h00, spi_dout_oe});
  endtask
  // busy readout first, then bounded poll for ready
  task automatic ready(input logic [7:0] e);
    int i;
    frm(status_read_cmd, 8'h00, 1, st);
    chk("busy", busy_readout, st);
    for (i = 0; i < 10 && st === busy_readout; i++)
      frm(status_read_cmd, 8'h00, 1, st);
    if (st === busy_readout)
    begin
      errors++;
      complete_run();
    end
    chk("status", e, st);
  endtask
  ////////////////////////////////////////
  initial
  begin
    nrst = 1'b0;
    protect_n = 1'b1;
    errors = 0;
    compares = 0;
    seen_oe = 1'b0;
    void'($urandom(32'hEBD97310));
    repeat (8) @(posedge clock);
    nrst <= 1'b1;
    repeat (4) @(posedge clock);
    chk("oe", 8'h00, {7'h00, seen_oe});
    frm(status_read_cmd, 8'h00, 1, st);
    chk("status", stat(1'b0, 3'h0, 1'b0), st);
    frm(set_write_latch_cmd, 8'h00, 0, st);
    frm(status_read_cmd, 8'h00, 1, st);
    chk("status", stat(1'b0, 3'h0, 1'b1), st);
    frm(clear_write_latch_cmd, 8'h00, 0, st);
    frm(status_read_cmd, 8'h00, 1, st);
    chk("status", stat(1'b0, 3'h0, 1'b0), st);
    // fill last and first page from random offsets
    // second pass in mode 3, with a pause inside the frame
    for (int k = 0; k < 2; k++)
    begin
      host_u.mode3 = k[0];
      frm(set_write_latch_cmd, 8'h00, 0, st);
      wr({k[0] ? 6'h00 : 6'h3F, 5'($urandom)}, 32, 1'b1, 1'b0, k[0]);
      ready(stat(1'b0, 3'h0, 1'b0));
    end
    rd(11'h7F0, 48);
    // paused read releases the output
    host_u.sel_on();
    hdr(array_read_cmd, 11'h7F8);
    host_u.xfer(8'h00, r);
    chk("read", mem[11'h7F8], r);
    host_u.hold(2, q);
    chk("hold", 8'h00, {7'h00, q});
    host_u.sel_off();
    host_u.mode3 = 1'b0;
    wr(11'h010, 1, 1'b0, 1'b1, 1'b0);
    frm(status_read_cmd, 8'h00, 1, st);
    chk("busy", 8'h00, {7'h00, st[st_busy]});
    @(posedge clock) protect_n <= 1'b0;
    frm(set_write_latch_cmd, 8'h00, 0, st);
    frm(status_write_cmd, 8'h7F, 1, st);
    ready(stat(1'b0, 3'h7, 1'b0));
    frm(set_write_latch_cmd, 8'h00, 0, st);
    wr({6'h3F, 5'($urandom)}, 1, 1'b0, 1'b0, 1'b0);
    frm(status_read_cmd, 8'h00, 1, st);
    chk("status", stat(1'b0, 3'h7, 1'b1), st);
    rd(11'h7E0, 32);
    frm(status_write_cmd, 8'h80, 1, st);
    ready(stat(1'b1, 3'h0, 1'b0));
    frm(set_write_latch_cmd, 8'h00, 0, st);
    frm(status_write_cmd, 8'h00, 1, st);
    frm(status_read_cmd, 8'h00, 1, st);
    chk("status", stat(1'b1, 3'h0, 1'b1), st);
    wr(11'h005, 1, 1'b1, 1'b0, 1'b0);
    // array read during the write cycle is ignored
    seen_oe = 1'b0;
    frm(array_read_cmd, 8'h00, 3, st);
    chk("oe", 8'h00, {7'h00, seen_oe});
    ready(stat(1'b1, 3'h0, 1'b0));
    rd(11'h000, 8);
    @(posedge clock) protect_n <= 1'b1;
    frm(set_write_latch_cmd, 8'h00, 0, st);
    frm(status_write_cmd, 8'h00, 1, st);
    ready(stat(1'b0, 3'h0, 1'b0));
    seen_oe = 1'b0;
    frm(8'hA5, 8'hFF, 2, st);
    chk("oe", 8'h00, {7'h00, seen_oe});
    complete_run();
  end
endmodule
`default_nettype wire
